//--- swc_supervisor.sv
// Service window timer with clock monitor driving one active-low event pin.
// Assumes all inputs synchronous to core_clk; the pin pullup and threshold sit outside.
//
// Operation
// - Enable bit zero makes pin the event output
// - Timer and monitor inactive while reset held
// - Reset leaves longest window and monitor enabled
// - Single first keyed write fixes window, monitor
// - Later writes compared, never stored
// - Matching service restarts; any mismatch fires event
// - Bad key on first write fires event
// - Event output active low, released to pullup
// - Hold low 16-32 cycles after pin low
// - Window restarts when pin returns high
// - Service ignored while event pin low
// - Clock error holds low, releases after hold
// - Accept above 10 kHz, reject below 10 Hz
// - Key field reads back as zeros
// - Window timer frozen in halt and idle
// - Clock monitor stays active in halt, idle
// - RC without delay: window resumes after halt
// - Crystal or delay set: window reloads after halt
// - Idle exit performs automatic service
// - Idle flag sets on bit twelve toggle
// - First service accepted anywhere in maximum window
// - Lower limit 2048, upper 8k to 64k
// - Register: select 7:6, key 5:1, monitor 0
`timescale 1ns/10ps
`default_nettype none
module swc_supervisor
  import swc_pkg::*;
(
  // Clock and resets
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       power_on_rst,
  // Option configuration
  input  wire logic [7:0] option_config_register,
  // Service register access
  input  wire logic       svr_wr,
  input  wire logic       svr_rd,
  input  wire logic [7:0] svr_wdata,
  output var  logic [7:0] svr_rdata,
  // Low-power modes and oscillator options
  input  wire logic       halt_mode,
  input  wire logic       idle_mode,
  input  wire logic       rc_osc_option,
  input  wire logic       clock_delay_bit,
  // Idle timer
  input  wire logic       idle_pend_clr,
  output var  logic       idle_timer_pending_flag,
  // Clock monitor probes
  input  wire logic       osc_probe,
  input  wire logic       ref_tick,
  // Port G bit one pin
  input  wire logic       port_g_bit_one_pin_in,
  output var  logic       port_g_bit_one_pin_out,
  output var  logic       port_g_bit_one_pin_oe_n,
  // Port G bit one as plain port
  input  wire logic       gpio_out,
  input  wire logic       gpio_oe_n,
  // Status
  output var  logic       sup_active
);

  swc_ev_state_t state_r;
  swc_ev_state_t state_nxt;
  swc_svr_t      wd;
  logic          sup_en_r;
  logic [1:0]    sel_r;
  logic          cm_en_r;
  logic          first_done_r;
  logic [16:0]   cnt_r;
  logic [16:0]   upper_lim;
  logic [5:0]    hold_cnt_r;
  logic          halt_d_r;
  logic          idle_d_r;
  logic [15:0]   idle_cnt_r;
  logic          cm_err;
  logic          frozen;
  logic          halt_exit;
  logic          idle_exit;
  logic          halt_reload;
  logic          svc;
  logic          key_ok;
  logic          match;
  logic          first_ok;
  logic          svc_ok;
  logic          svc_err;
  logic          expire;
  logic          tmr_err;
  logic          drive_low_nxt;
  logic          idle_tgl;

  function automatic logic [16:0] upper_of(input logic [1:0] sel);
    case (sel)
      2'h0:    upper_of = UPPER_8K;
      2'h1:    upper_of = UPPER_16K;
      2'h2:    upper_of = UPPER_32K;
      default: upper_of = UPPER_64K;
    endcase
  endfunction

  // Supervisor enable follows the option bit, off during reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sup_en_r <= 1'b0;
    else
      sup_en_r <= ~option_config_register[OPT_EN_BIT];
  end

  swc_clk_check u_clk_check (
    .core_clk  (core_clk),
    .rst       (rst),
    .enable    (sup_en_r && cm_en_r),
    .osc_probe (osc_probe),
    .ref_tick  (ref_tick),
    .freq_err  (cm_err)
  );
  // Monitor is not gated by halt or idle, so a stopped clock in halt is flagged

  assign wd          = swc_svr_t'(svr_wdata);
  assign upper_lim   = upper_of(sel_r);
  assign frozen      = halt_mode | idle_mode;
  assign halt_exit   = halt_d_r & ~halt_mode;
  assign idle_exit   = idle_d_r & ~idle_mode;
  assign halt_reload = halt_exit & ~(rc_osc_option & ~clock_delay_bit);
  assign svc         = sup_en_r && svr_wr && (state_r == EV_RUN) && port_g_bit_one_pin_in;
  assign key_ok      = (wd.key == SVR_KEY);
  assign match       = key_ok && (wd.sel == sel_r) && (wd.cm == cm_en_r);
  assign first_ok    = svc && !first_done_r && key_ok;
  assign svc_ok      = svc && first_done_r && match && (cnt_r >= LOWER_LIMIT);
  assign svc_err     = svc && !(first_ok || svc_ok);
  assign expire      = sup_en_r && (state_r == EV_RUN) && !frozen && (cnt_r == upper_lim);
  assign tmr_err     = svc_err | expire;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      halt_d_r <= 1'b0;
      idle_d_r <= 1'b0;
    end
    else
    begin
      halt_d_r <= halt_mode;
      idle_d_r <= idle_mode;
    end
  end

  // First write locks window select and monitor enable; only a valid key loads them
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sel_r        <= SVR_SEL_RST;
      cm_en_r      <= SVR_CM_RST;
      first_done_r <= 1'b0;
    end
    else if (svc && !first_done_r)
    begin
      first_done_r <= 1'b1;
      if (key_ok)
      begin
        sel_r   <= wd.sel;
        cm_en_r <= wd.cm;
      end
    end
  end

  // Window counter
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cnt_r <= 17'h00000;
    else if (!sup_en_r || state_r != EV_RUN)
      cnt_r <= 17'h00000;
    else if (first_ok || svc_ok)
      cnt_r <= 17'h00000;
    else if (idle_exit)
      cnt_r <= 17'h00000;
    else if (halt_reload)
      cnt_r <= 17'h00000;
    else if (!frozen)
      cnt_r <= cnt_r + 17'h00001;
  end

  // Event sequencing
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      EV_RUN:
        if (tmr_err || cm_err)
          state_nxt = EV_PULL;
      EV_PULL:
        if (!port_g_bit_one_pin_in && !cm_err)
          state_nxt = EV_HOLD;
      EV_HOLD:
        if (cm_err)
          state_nxt = EV_PULL;
        else if (hold_cnt_r == HOLD_CYCLES - 6'h01)
          state_nxt = EV_REL;
      EV_REL:
        if (cm_err)
          state_nxt = EV_PULL;
        else if (port_g_bit_one_pin_in)
          state_nxt = EV_RUN;
      default:
        state_nxt = EV_RUN;
    endcase
    if (!sup_en_r)
      state_nxt = EV_RUN;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      state_r <= EV_RUN;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      hold_cnt_r <= 6'h00;
    else if (state_r == EV_HOLD)
      hold_cnt_r <= hold_cnt_r + 6'h01;
    else
      hold_cnt_r <= 6'h00;
  end

  // Pin drive: open-drain low only while sup_en_r is set, released to the external pullup; else gpio_out and gpio_oe_n pass through
  assign drive_low_nxt = (state_nxt == EV_PULL) || (state_nxt == EV_HOLD);

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      port_g_bit_one_pin_out  <= 1'b0;
      port_g_bit_one_pin_oe_n <= 1'b1;
    end
    else if (sup_en_r)
    begin
      port_g_bit_one_pin_out  <= 1'b0;
      port_g_bit_one_pin_oe_n <= ~drive_low_nxt;
    end
    else
    begin
      port_g_bit_one_pin_out  <= gpio_out;
      port_g_bit_one_pin_oe_n <= gpio_oe_n;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      sup_active <= 1'b0;
    else
      sup_active <= sup_en_r;
  end

  // Read hides the key
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      svr_rdata <= 8'h00;
    else if (svr_rd)
      svr_rdata <= {sel_r, SVR_KEY_READ, cm_en_r};
  end

  // Idle timer: only power-on reset clears it
  assign idle_tgl = !halt_mode && (&idle_cnt_r[IDLE_FLAG_BIT-1:0]);

  always_ff @(posedge core_clk or posedge power_on_rst)
  begin
    if (power_on_rst)
      idle_cnt_r <= 16'h0000;
    else if (!halt_mode)
      idle_cnt_r <= idle_cnt_r + 16'h0001;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      idle_timer_pending_flag <= 1'b0;
    else if (idle_tgl)
      idle_timer_pending_flag <= 1'b1;
    else if (idle_pend_clr)
      idle_timer_pending_flag <= 1'b0;
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  pin_role_a: assert property (sup_en_r |=> port_g_bit_one_pin_out == 1'b0)
    else $error("event pin drives high level");
  reset_defaults_a: assert property (!first_done_r |-> sel_r == SVR_SEL_RST && cm_en_r)
    else $error("reset window or monitor default lost");
  config_lock_a: assert property (first_done_r && svr_wr |=> $stable(sel_r) && $stable(cm_en_r))
    else $error("configuration changed after first write");
  mismatch_fires_a: assert property (svc && first_done_r && !match |=> state_r == EV_PULL)
    else $error("mismatched service did not fire");
  bad_key_a: assert property (svc && !first_done_r && !key_ok |=> state_r == EV_PULL)
    else $error("bad first key did not fire");
  early_service_a: assert property (svc && first_done_r && match && cnt_r < LOWER_LIMIT
    |=> state_r == EV_PULL) else $error("early service accepted");
  hold_length_a: assert property ($rose(state_r == EV_REL) && $past(state_r) == EV_HOLD
    |-> $past(hold_cnt_r) == HOLD_CYCLES - 6'h01 && HOLD_CYCLES >= HOLD_MIN
        && HOLD_CYCLES <= HOLD_MAX) else $error("hold length wrong");
  ignore_low_a: assert property (svr_wr && !port_g_bit_one_pin_in
    |=> $stable(first_done_r) && $stable(sel_r)) else $error("service taken while pin low");
  clock_hold_a: assert property (sup_en_r && cm_err |=> ##1 !port_g_bit_one_pin_oe_n)
    else $error("clock error did not pull pin low");
  key_hidden_a: assert property (svr_rd |=> svr_rdata[5:1] == SVR_KEY_READ)
    else $error("key visible on read");
  frozen_count_a: assert property (frozen && !svr_wr && state_r == EV_RUN |=> $stable(cnt_r))
    else $error("window ran in low-power mode");
  idle_restart_a: assert property (idle_exit && state_r == EV_RUN |=> cnt_r == 17'h00000)
    else $error("idle exit did not restart window");
  first_anywhere_a: assert property (first_ok |=> state_r == EV_RUN && cnt_r == 17'h00000)
    else $error("first service rejected");
  idle_flag_a: assert property (idle_tgl |=> idle_timer_pending_flag)
    else $error("idle flag missed toggle");
  window_expire_a: assert property (expire |=> !port_g_bit_one_pin_oe_n)
    else $error("window expiry did not fire");
  window_restart_a: assert property (state_r == EV_REL && port_g_bit_one_pin_in && !cm_err
    |=> state_r == EV_RUN && cnt_r == 17'h00000) else $error("window did not restart");
  halt_reload_a: assert property (halt_reload && state_r == EV_RUN |=> cnt_r == 17'h00000)
    else $error("halt exit did not reload window");

  valid_service_c: cover property (svc_ok ##1 cnt_r == 17'h00000);
  timeout_c: cover property (expire ##[1:40] state_r == EV_REL);
  clock_error_c: cover property (cm_err ##1 state_r == EV_PULL);
  halt_resume_c: cover property (halt_exit && !halt_reload && state_r == EV_RUN);

endmodule
`default_nettype wire

//--- swc_pkg.sv
// Constants, service register layout and event states of the service window supervisor.
// Assumes a single instruction-cycle clock domain.
package swc_pkg;

  // Option configuration: supervisor enable bit (0 = active)
  localparam int          OPT_EN_BIT    = 2;

  // Service register layout, msb to lsb: window select, key, clock monitor enable
  typedef struct packed {
    logic [1:0] sel;
    logic [4:0] key;
    logic       cm;
  } swc_svr_t;

  localparam logic [4:0]  SVR_KEY       = 5'h0c;
  localparam logic [4:0]  SVR_KEY_READ  = 5'h00;
  localparam logic [1:0]  SVR_SEL_RST   = 2'h3;
  localparam logic        SVR_CM_RST    = 1'b1;

  // Service window limits in instruction cycles
  localparam logic [16:0] LOWER_LIMIT   = 17'h00800;
  localparam logic [16:0] UPPER_8K      = 17'h02000;
  localparam logic [16:0] UPPER_16K     = 17'h04000;
  localparam logic [16:0] UPPER_32K     = 17'h08000;
  localparam logic [16:0] UPPER_64K     = 17'h10000;

  // Low hold after the pin is seen low, inside the 16..32 cycle band
  localparam logic [5:0]  HOLD_MIN      = 6'h10;
  localparam logic [5:0]  HOLD_MAX      = 6'h20;
  localparam logic [5:0]  HOLD_CYCLES   = 6'h18;

  // Idle timer
  localparam int          IDLE_FLAG_BIT = 12;

  // Clock monitor: reference tick period and longest tolerated gap between edges
  localparam int          CMON_REF_PERIOD_US = 1000;
  localparam int          CMON_MAX_GAP_MS    = 50;
  localparam logic [7:0]  CMON_GAP_LIMIT     =
    8'((CMON_MAX_GAP_MS * 1000) / CMON_REF_PERIOD_US);

  // Event output states, Gray coded along run, pull, hold, release
  typedef enum logic [1:0] {
    EV_RUN  = 2'b00,
    EV_PULL = 2'b01,
    EV_HOLD = 2'b11,
    EV_REL  = 2'b10
  } swc_ev_state_t;

endpackage

//--- swc_clk_check.sv
// Clock frequency check: flags a gap between oscillator edges that is too long.
// Assumes osc_probe and ref_tick are synchronous; ref_tick comes from an independent timebase.
`timescale 1ns/10ps
`default_nettype none
module swc_clk_check
  import swc_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Control
  input  wire logic enable,
  // Sensed oscillator and reference
  input  wire logic osc_probe,
  input  wire logic ref_tick,
  // Result
  output var  logic freq_err
);

  logic       osc_d_r;
  logic [7:0] gap_r;
  logic       osc_edge;

  assign osc_edge = osc_probe & ~osc_d_r;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      osc_d_r <= 1'b0;
    else
      osc_d_r <= osc_probe;
  end

  // Gap of 50 ms, a 20 Hz period, rejects, edges faster than 10 kHz always clear it
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      gap_r <= 8'h00;
    else if (!enable || osc_edge)
      gap_r <= 8'h00;
    else if (ref_tick && gap_r != CMON_GAP_LIMIT)
      gap_r <= gap_r + 8'h01;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      freq_err <= 1'b0;
    else
      freq_err <= enable && (gap_r == CMON_GAP_LIMIT) && !osc_edge;
  end

  gap_reject_a: assert property (@(posedge core_clk) disable iff (rst)
    (enable && gap_r == CMON_GAP_LIMIT && !osc_edge) |=> freq_err)
    else $error("clock gap not rejected");

  edge_clears_a: assert property (@(posedge core_clk) disable iff (rst)
    osc_edge |=> !freq_err) else $error("oscillator edge did not clear error");

endmodule
`default_nettype wire

//--- swc_pin_host.sv
// Host-side model of port G bit one: weak pullup and a slow input threshold.
// Assumes oe_n low means the supervisor drives the pin; nothing else drives it.
`timescale 1ns/10ps
`default_nettype none
module swc_pin_host #(
  parameter int SETTLE = 1
)
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Drive from the supervisor
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // Level seen back on the pin
  output var  logic pin_in
);
  logic       lvl;
  logic [7:0] sh_r;

  // Released pin floats up to the weak pullup
  assign lvl = pin_oe_n ? 1'b1 : pin_out;

  // Edge reaches the threshold SETTLE cycles late, 1 to 8
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      sh_r <= 8'hff;
    end
    else
    begin
      sh_r <= {sh_r[6:0], lvl};
    end
  end

  assign pin_in = sh_r[SETTLE-1];
endmodule
`default_nettype wire

//--- service_window_timer_clock_check_tb_top.sv
// Self-checking bench for the service window supervisor with a pin host model.
// Assumes 25 MHz core clock; the bench plays software, oscillator and timebase.
`timescale 1ns/10ps
`default_nettype none
module service_window_timer_clock_check_tb_top;
  import swc_pkg::*;

  localparam logic [7:0] GOOD = {2'h0, SVR_KEY, 1'b1};
  localparam logic [7:0] TBL [4] = '{GOOD, {2'h1, SVR_KEY, 1'b1},
                                     {2'h0, SVR_KEY ^ 5'h01, 1'b1}, {2'h0, SVR_KEY, 1'b0}};

  logic       core_clk, rst, por, svr_wr, svr_rd, halt, idle, rc_opt, dly, pclr;
  logic       osc, tick, gp_o, gp_oe_n, osc_run, pin_in, pin_out, oe_n, flag, sup_act, oe_q;
  logic [7:0] opt, wdata, rdata, rd_v;
  logic [1:0] tick_q;
  int         n_fail, samples_checked, ev_cnt, n, e, hold_n;

  swc_supervisor i_dut (
    .core_clk(core_clk), .rst(rst), .power_on_rst(por),
    .option_config_register(opt), .svr_wr(svr_wr), .svr_rd(svr_rd),
    .svr_wdata(wdata), .svr_rdata(rdata), .halt_mode(halt), .idle_mode(idle),
    .rc_osc_option(rc_opt), .clock_delay_bit(dly), .idle_pend_clr(pclr),
    .idle_timer_pending_flag(flag), .osc_probe(osc), .ref_tick(tick),
    .port_g_bit_one_pin_in(pin_in), .port_g_bit_one_pin_out(pin_out),
    .port_g_bit_one_pin_oe_n(oe_n), .gpio_out(gp_o), .gpio_oe_n(gp_oe_n),
    .sup_active(sup_act)
  );

  swc_pin_host #(.SETTLE(2)) i_host (
    .core_clk(core_clk), .rst(rst), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_in(pin_in)
  );

  always #20 core_clk = ~core_clk;

  // Fast oscillator and a shortened reference tick, one every 4 cycles
  always @(posedge core_clk)
  begin
    if (osc_run)
      osc <= ~osc;
    tick_q <= tick_q + 2'h1;
    tick   <= (tick_q == 2'h3);
  end

  // Count events, and cycles driven low while the pin reads low
  always @(negedge core_clk)
  begin
    oe_q <= oe_n;
    if (oe_q === 1'b1 && oe_n === 1'b0)
    begin
      ev_cnt++;
      hold_n = 0;
    end
    else if (oe_n === 1'b0 && pin_in === 1'b0)
      hold_n++;
  end

  task automatic close_out();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] in_rng(input int v, input int lo, input int hi);
    return (v >= lo && v <= hi) ? 32'h1 : 32'h0;
  endfunction

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] d);
    @(posedge core_clk);
    svr_wr <= 1'b1;
    wdata  <= d;
    @(posedge core_clk);
    svr_wr <= 1'b0;
    #1;
  endtask

  task automatic rd();
    @(posedge core_clk);
    svr_rd <= 1'b1;
    @(posedge core_clk);
    svr_rd <= 1'b0;
    cyc(1);
    rd_v = rdata;
  endtask

  task automatic pulse_clr();
    @(posedge core_clk);
    pclr <= 1'b1;
    @(posedge core_clk);
    pclr <= 1'b0;
    #1;
  endtask

  // Bounded wait on enable (0), pin (1) or idle flag (2)
  task automatic wait_lvl(input int s, input logic v, input int lim, output int k);
    k = 0;
    while (((s == 0) ? oe_n : (s == 1) ? pin_in : flag) !== v)
    begin
      if (k >= lim)
      begin
        n_fail++;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, k, lim);
        close_out();
      end
      cyc(1);
      k++;
    end
  endtask

  task automatic handle_ev();
    int k;
    wait_lvl(0, 1'b0, 20, k);
    wait_lvl(1, 1'b0, 20, k);
    wr(8'h00);
    wait_lvl(0, 1'b1, 60, k);
    chk(in_rng(hold_n, 16, 32), 1);
    wait_lvl(1, 1'b1, 20, k);
  endtask

  task automatic mode_run(input logic h, input logic d, input int exp_n);
    int k;
    int e0;
    cyc(5000);
    @(posedge core_clk);
    halt <= h;
    idle <= ~h;
    dly  <= d;
    e0 = ev_cnt;
    cyc(4000);
    chk(ev_cnt - e0, 0);
    @(posedge core_clk);
    halt <= 1'b0;
    idle <= 1'b0;
    #1;
    wait_lvl(0, 1'b0, 9000, k);
    chk(in_rng(k, exp_n - 12, exp_n + 12), 1);
    handle_ev();
  endtask

  initial
  begin
    {core_clk, svr_wr, svr_rd, halt, idle, dly, pclr, osc, tick, gp_o, tick_q, oe_q} = '0;
    {opt, wdata} = '0;
    {rst, por, rc_opt, gp_oe_n, osc_run} = '1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    por <= 1'b0;
    cyc(4);
    chk(sup_act, 1'b1);
    chk(oe_n, 1'b1);
    rd();
    chk(rd_v, {SVR_SEL_RST, SVR_KEY_READ, SVR_CM_RST});
    wr(GOOD);
    cyc(20);
    chk(ev_cnt, 0);
    rd();
    chk(rd_v, {2'h0, SVR_KEY_READ, 1'b1});
    // Service inside the lower limit
    wr(GOOD);
    handle_ev();
    wait_lvl(0, 1'b0, 8300, n);
    chk(in_rng(n, int'(UPPER_8K) - 6, int'(UPPER_8K) + 8), 1);
    handle_ev();
    for (int i = 0; i < 4; i++)
    begin
      cyc(2100);
      e = ev_cnt;
      wr(TBL[i]);
      cyc(8);
      chk(ev_cnt - e, (i > 0) ? 1 : 0);
      if (i > 0)
        handle_ev();
    end
    rd();
    chk(rd_v, {2'h0, SVR_KEY_READ, 1'b1});
    mode_run(1'b1, 1'b0, int'(UPPER_8K) - 5000);
    mode_run(1'b1, 1'b1, int'(UPPER_8K));
    mode_run(1'b0, 1'b0, int'(UPPER_8K));
    // Oscillator stops while halted
    @(posedge core_clk);
    halt    <= 1'b1;
    osc_run <= 1'b0;
    #1;
    wait_lvl(0, 1'b0, 300, n);
    cyc(400);
    chk(oe_n, 1'b0);
    @(posedge core_clk);
    osc_run <= 1'b1;
    halt    <= 1'b0;
    #1;
    wait_lvl(0, 1'b1, 80, n);
    chk(in_rng(n, 16, 32), 1);
    wait_lvl(1, 1'b1, 20, n);
    pulse_clr();
    wait_lvl(2, 1'b1, 4200, n);
    pulse_clr();
    chk(flag, 1'b0);
    wait_lvl(2, 1'b1, 4200, n);
    chk(in_rng(n, 4090, 4097), 1);
    @(posedge core_clk);
    rst <= 1'b1;
    cyc(16);
    chk(oe_n, 1'b1);
    chk(sup_act, 1'b0);
    @(posedge core_clk);
    rst <= 1'b0;
    cyc(4);
    // Idle counter keeps its phase across the reset
    wait_lvl(2, 1'b1, 4200, n);
    chk(in_rng(n, 4070, 4078), 1);
    wr({2'h0, SVR_KEY ^ 5'h1f, 1'b1});
    handle_ev();
    @(posedge core_clk);
    opt     <= 8'h04;
    gp_o    <= 1'b1;
    gp_oe_n <= 1'b0;
    cyc(4);
    chk({sup_act, pin_out, oe_n}, 3'h2);
    close_out();
  end
endmodule
`default_nettype wire
